/* File: core/isw_slave.sv */
// I2C slave word handler top: address match, word shifting, clock stretching.
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module isw_slave
  import isw_pkg::*;
#(
  parameter int CLOCK_LOW_PERIOD_CYC = ISW_CLOCK_LOW_PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic arb_lost_in,
  output logic transfer_interrupt
);
  isw_pins_type pins;
  isw_evt_type evt;
  logic wr_stb, rd_stb;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic rd_ok, wr_ok;
  isw_state_type state_reg, state_next;
  logic [7:0] shift_reg;
  logic [7:0] data_buffer_reg;
  logic [3:0] bit_cnt_reg;
  logic [2:0] word_bit_count_reg;
  logic [6:0] own_addr_reg;
  logic pend_reg, trx_reg, master_select_reg, aas_reg, gc_reg, al_reg, lrb_reg, busy_reg;
  logic ack_drive_reg, stretch_reg, irq_reg;
  logic sel_reg;
  isw_pins_type pins_in;
  logic [15:0] low_cnt_reg;
  logic [3:0] word_bits;
  logic word_done, addr_match, is_gc, sw_release, buf_access;
  logic data_wr, data_rd, ctrl_wr, addr_wr;

  ////////////////////////////////////////////////////////////////
  // Pin synchroniser and register bus
  assign pins_in = '{scl: scl_i, sda: sda_i};
  isw_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pins_raw(pins_in),
    .pins(pins),
    .evt(evt)
  );

  isw_axil u_axil (
    .clk_sys(clk_sys),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_stb(rd_stb),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok),
    .wr_ok(wr_ok)
  );

  ////////////////////////////////////////////////////////////////
  // Register decode; only byte lane 0 carries any field
  assign data_wr = wr_stb & (wr_addr == ISW_OFF_DATA) & wr_strb[0];
  assign ctrl_wr = wr_stb & (wr_addr == ISW_OFF_CTRL) & wr_strb[0];
  assign addr_wr = wr_stb & (wr_addr == ISW_OFF_ADDR) & wr_strb[0];
  assign data_rd = rd_stb & (rd_addr == ISW_OFF_DATA);
  assign wr_ok = wr_ok_f(wr_addr);
  assign rd_ok = wr_ok_f(rd_addr) | (rd_addr == ISW_OFF_STAT);
  assign rd_data = (rd_addr == ISW_OFF_DATA) ? {24'h0, data_buffer_reg} :
                   (rd_addr == ISW_OFF_CTRL) ? {25'h0, word_bit_count_reg, 1'b0, master_select_reg,
                                                trx_reg, pend_reg} :
                   (rd_addr == ISW_OFF_STAT) ? {24'h0, busy_reg, master_select_reg, pend_reg, trx_reg,
                                                al_reg, aas_reg, gc_reg, lrb_reg} :
                   (rd_addr == ISW_OFF_ADDR) ? {25'h0, own_addr_reg} : 32'h0;

  // Writable offsets, shared by read and write decode
  function automatic logic wr_ok_f(input logic [7:0] a);
    wr_ok_f = (a == ISW_OFF_DATA) | (a == ISW_OFF_CTRL) | (a == ISW_OFF_ADDR);
  endfunction : wr_ok_f

  // Word length: a count of zero means eight bits
  assign word_bits = (word_bit_count_reg == ISW_BC_FULL) ? ISW_BITS_FULL : {1'b0, word_bit_count_reg};
  assign addr_match = (shift_reg[7:1] == own_addr_reg);
  assign is_gc = (shift_reg == 8'h00);
  // Release by buffer access or pending set
  assign buf_access = data_wr | data_rd;
  assign sw_release = buf_access | (ctrl_wr & wr_data[ISW_CTRL_PEND]);
  assign word_done = (state_reg == ISW_ACK) & evt.scl_fall;

  ////////////////////////////////////////////////////////////////
  // Word engine next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ISW_IDLE: if (evt.start) state_next = ISW_ADDR;
      ISW_ADDR: if (evt.scl_fall & (bit_cnt_reg == ISW_BITS_FULL)) state_next = ISW_ACK;
      ISW_DATA: if (evt.scl_fall & (bit_cnt_reg == word_bits)) state_next = ISW_ACK;
      ISW_ACK: if (evt.scl_fall) state_next = (sel_reg | al_reg) ? ISW_HOLD : ISW_IDLE;
      // Leave the hold as SCL is let go, so the first rise of the next word is counted
      ISW_HOLD: if (~stretch_reg) state_next = ISW_DATA;
      default: state_next = ISW_IDLE;
    endcase
    if (evt.stop) state_next = ISW_IDLE;
    else if (evt.start) state_next = ISW_ADDR;
  end

  // State, bit counter and shifter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ISW_IDLE;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (evt.start | (state_reg == ISW_ACK)) bit_cnt_reg <= '0;
      else if (evt.scl_rise & ((state_reg == ISW_ADDR) | (state_reg == ISW_DATA)))
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (evt.scl_rise & ((state_reg == ISW_ADDR) | ((state_reg == ISW_DATA) & ~trx_reg)))
        shift_reg <= {shift_reg[6:0], pins.sda};
      else if (data_wr) shift_reg <= wr_data[7:0];
      else if (evt.scl_fall & (state_reg == ISW_DATA) & trx_reg) shift_reg <= {shift_reg[6:0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Flags; hardware events outrank software writes in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_reg <= 1'b1;
      trx_reg <= 1'b0;
      master_select_reg <= 1'b0;
      aas_reg <= 1'b0;
      gc_reg <= 1'b0;
      al_reg <= 1'b0;
      lrb_reg <= 1'b0;
      busy_reg <= 1'b0;
      sel_reg <= 1'b0;
      word_bit_count_reg <= ISW_BC_FULL;
      own_addr_reg <= '0;
      data_buffer_reg <= '0;
    end else begin
      if (addr_wr) own_addr_reg <= wr_data[6:0];
      if (ctrl_wr) begin
        word_bit_count_reg <= wr_data[ISW_CTRL_BC_LO +: 3];
        // Software drops direction to let the bus go
        trx_reg <= wr_data[ISW_CTRL_TRX];
        master_select_reg <= wr_data[ISW_CTRL_MST];
      end
      if (ctrl_wr & wr_data[ISW_CTRL_PEND]) pend_reg <= 1'b1;
      else if (buf_access) pend_reg <= 1'b1;
      // Last bit sampled on SCL rise
      if (evt.scl_rise) lrb_reg <= pins.sda;
      if (evt.start) busy_reg <= 1'b1;
      else if (evt.stop) busy_reg <= 1'b0;
      if (arb_lost_in & master_select_reg) begin
        al_reg <= 1'b1;
        master_select_reg <= 1'b0;
      end else if (evt.start | evt.stop) al_reg <= 1'b0;
      if (evt.start | evt.stop) begin
        gc_reg <= 1'b0;
        aas_reg <= 1'b0;
        sel_reg <= 1'b0;
      end else if ((state_reg == ISW_ADDR) & (state_next == ISW_ACK)) begin
        gc_reg <= is_gc;
        // Addressed on own address or general call
        aas_reg <= is_gc | addr_match;
        // Stays set for the frame, so every later word interrupts too
        sel_reg <= is_gc | addr_match;
        // General call or write bit leaves it clear
        trx_reg <= (addr_match & ~is_gc) ? shift_reg[0] : 1'b0;
      end else if ((state_reg == ISW_DATA) & (state_next == ISW_ACK)) begin
        aas_reg <= 1'b0;
        if (~trx_reg) data_buffer_reg <= shift_reg;
      end
      if (word_done & (state_next == ISW_HOLD)) pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Stretch, acknowledge drive and the clock low hold after release
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stretch_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      low_cnt_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= 1'b0;
      if (word_done & (state_next == ISW_HOLD)) begin
        irq_reg <= 1'b1;
        stretch_reg <= 1'b1;
        low_cnt_reg <= '0;
      end else if (stretch_reg & ~pend_reg) begin
        low_cnt_reg <= '0;
      end else if (stretch_reg) begin
        if (low_cnt_reg >= 16'(CLOCK_LOW_PERIOD_CYC - 1)) stretch_reg <= 1'b0;
        else low_cnt_reg <= low_cnt_reg + 16'h1;
      end
      if (evt.stop | evt.start) stretch_reg <= 1'b0;
      // Acknowledge held through the whole ninth clock, for an own address or general call and for every data word received
      ack_drive_reg <= (state_next == ISW_ACK) &
                       (((state_reg == ISW_ADDR) & (is_gc | addr_match)) |
                        ((state_reg == ISW_DATA) & ~trx_reg) | ((state_reg == ISW_ACK) & ack_drive_reg));
    end
  end

  // Open-drain pins: enable low drives a zero
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = ~stretch_reg;
  // First bit goes out while SCL is still held, so SDA never moves under a high clock
  assign sda_oe_n = ~(ack_drive_reg |
                      (((state_reg == ISW_DATA) | ((state_reg == ISW_HOLD) & pend_reg)) & trx_reg & ~shift_reg[7]));
  // Interrupt pulse also follows lost arbitration
  assign transfer_interrupt = irq_reg;

  ////////////////////////////////////////////////////////////////
  // Checks
  property p_int_clears_pend;
    @(posedge clk_sys) disable iff (rst) transfer_interrupt |-> (~pend_reg & ~scl_oe_n);
  endproperty
  a_int_clears_pend: assert property (p_int_clears_pend) else $error("pending not cleared at interrupt");
  property p_release;
    @(posedge clk_sys) disable iff (rst)
      (stretch_reg & pend_reg & ~evt.start & ~evt.stop) [*2] |-> ##[0:1000] ~stretch_reg;
  endproperty
  a_release: assert property (p_release) else $error("SCL not released");
  property p_lrb;
    @(posedge clk_sys) disable iff (rst) evt.scl_rise |=> (lrb_reg == $past(pins.sda));
  endproperty
  a_lrb: assert property (p_lrb) else $error("last bit wrong");
  property p_gc_clear;
    @(posedge clk_sys) disable iff (rst) (evt.start | evt.stop) |=> ~gc_reg;
  endproperty
  a_gc_clear: assert property (p_gc_clear) else $error("general call not cleared");
  property p_al;
    @(posedge clk_sys) disable iff (rst) (arb_lost_in & master_select_reg) |=> (al_reg & ~master_select_reg);
  endproperty
  a_al: assert property (p_al) else $error("lost arbitration not taken");
  property p_gc_dir;
    @(posedge clk_sys) disable iff (rst) $rose(gc_reg) |-> (~trx_reg & aas_reg);
  endproperty
  a_gc_dir: assert property (p_gc_dir) else $error("general call direction wrong");
  property p_irq_word;
    @(posedge clk_sys) disable iff (rst) $rose(stretch_reg) |-> transfer_interrupt;
  endproperty
  a_irq_word: assert property (p_irq_word) else $error("stretch without interrupt");
  property p_no_early;
    @(posedge clk_sys) disable iff (rst)
      (stretch_reg & ~pend_reg) |=> (stretch_reg | evt.start | evt.stop | $past(evt.start | evt.stop));
  endproperty
  a_no_early: assert property (p_no_early) else $error("released while pending clear");
  property p_addr_dir;
    @(posedge clk_sys) disable iff (rst)
      ((state_reg == ISW_ADDR) & (state_next == ISW_ACK) & addr_match & ~is_gc)
      |=> (trx_reg == $past(shift_reg[0]));
  endproperty
  a_addr_dir: assert property (p_addr_dir) else $error("direction not taken from address");
  property p_hold_exit;
    @(posedge clk_sys) disable iff (rst)
      ((state_reg == ISW_HOLD) & ~stretch_reg & ~evt.start & ~evt.stop) |=> (state_reg == ISW_DATA);
  endproperty
  a_hold_exit: assert property (p_hold_exit) else $error("word not resumed after release");
endmodule : isw_slave

/* File: core/isw_pkg.sv */
// Package for the I2C slave word handler: register map, fields and timing.
package isw_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] ISW_OFF_DATA = 8'h00;
  localparam logic [7:0] ISW_OFF_CTRL = 8'h04;
  localparam logic [7:0] ISW_OFF_STAT = 8'h08;
  localparam logic [7:0] ISW_OFF_ADDR = 8'h0c;
  // Control register fields
  localparam int ISW_CTRL_PEND = 0;
  localparam int ISW_CTRL_TRX = 1;
  localparam int ISW_CTRL_MST = 2;
  localparam int ISW_CTRL_BC_LO = 4;
  // Status register fields
  localparam int ISW_ST_LRB = 0;
  localparam int ISW_ST_GC = 1;
  localparam int ISW_ST_AAS = 2;
  localparam int ISW_ST_AL = 3;
  localparam int ISW_ST_TRX = 4;
  localparam int ISW_ST_PEND = 5;
  localparam int ISW_ST_MST = 6;
  localparam int ISW_ST_BB = 7;
  // AXI responses
  localparam logic [1:0] ISW_RESP_OKAY = 2'h0;
  localparam logic [1:0] ISW_RESP_SLVERR = 2'h2;
  // Clock low period held after a release, in ns, and as cycles at 200 MHz
  localparam int ISW_CLK_PERIOD_PS = 5000;
  localparam int ISW_CLOCK_LOW_PERIOD_NS = 4700;
  localparam int ISW_CLOCK_LOW_PERIOD_CYC = (ISW_CLOCK_LOW_PERIOD_NS * 1000 + ISW_CLK_PERIOD_PS - 1) / ISW_CLK_PERIOD_PS;
  localparam logic [2:0] ISW_BC_FULL = 3'h0;
  localparam logic [3:0] ISW_BITS_FULL = 4'h8;
  // Pin samples carried together
  typedef struct packed {
    logic scl;
    logic sda;
  } isw_pins_type;
  // Bus events found by the edge detector
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } isw_evt_type;
  // Word engine states
  typedef enum logic [4:0] {
    ISW_IDLE = 5'h01,
    ISW_ADDR = 5'h02,
    ISW_DATA = 5'h04,
    ISW_ACK = 5'h08,
    ISW_HOLD = 5'h10
  } isw_state_type;
endpackage : isw_pkg

/* File: core/isw_sync.sv */
// Two-stage synchroniser and bus edge / condition detector for SCL and SDA.
`timescale 1ns/1ps
module isw_sync
  import isw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire isw_pins_type pins_raw,
  output isw_pins_type pins,
  output isw_evt_type evt
);
  isw_pins_type meta_reg;
  isw_pins_type sync_reg;
  isw_pins_type prev_reg;

  ////////////////////////////////////////////////////////////////
  // First stage is read only by the second stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= '1;
      sync_reg <= '1;
      prev_reg <= '1;
    end else begin
      meta_reg <= pins_raw;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edges and start / stop conditions while SCL is high
  assign pins = sync_reg;
  assign evt.scl_rise = sync_reg.scl & ~prev_reg.scl;
  assign evt.scl_fall = ~sync_reg.scl & prev_reg.scl;
  assign evt.start = sync_reg.scl & prev_reg.scl & prev_reg.sda & ~sync_reg.sda;
  assign evt.stop = sync_reg.scl & prev_reg.scl & ~prev_reg.sda & sync_reg.sda;
endmodule : isw_sync

/* File: core/isw_axil.sv */
// AXI4-Lite slave front end: one write and one read at a time, word access.
`timescale 1ns/1ps
module isw_axil
  import isw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic rd_stb,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok,
  input wire logic wr_ok
);
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  ////////////////////////////////////////////////////////////////
  // Address and data are taken in either order, held until the write fires
  assign s_axi_awready = ~aw_have_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_reg & ~s_axi_bvalid;
  assign wr_stb = aw_have_reg & w_have_reg;
  assign wr_addr = awaddr_reg;
  assign wr_data = wdata_reg;
  assign wr_strb = wstrb_reg;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_stb = s_axi_arvalid & s_axi_arready;
  assign rd_addr = s_axi_araddr;

  // Write channel capture and response
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ISW_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_stb) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? ISW_RESP_OKAY : ISW_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data registered one cycle after the address is taken
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= ISW_RESP_OKAY;
    end else if (rd_stb) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? ISW_RESP_OKAY : ISW_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : isw_axil

/* File: dv/isw_i2c_master.sv */
// Behavioural I2C bus master that drives the far side of the slave.
`timescale 1ns/1ps
module isw_i2c_master (
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_drv,
  output logic sda_drv,
  output logic stall_err
);
  // Both lines released while idle, so the link clock stands still between frames
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    stall_err = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // waits out stretching
  // Bounded, so a slave that never lets go flags an error instead of hanging
  task automatic wait_high();
    int n;
    for (n = 0; n < 4000 && scl_w !== 1'b1; n++) #5;
    if (scl_w !== 1'b1) stall_err = 1'b1;
  endtask : wait_high
  // One 125 ns clock; SDA sampled in the high phase
  task automatic bit_io(input logic b, output logic s);
    sda_drv = b;
    #31.25 scl_drv = 1'b1;
    wait_high();
    #31.25 s = sda_w;
    #31.25 scl_drv = 1'b0;
    #31.25;
  endtask : bit_io
  // Start condition
  task automatic start();
    sda_drv = 1'b1;
    scl_drv = 1'b1;
    wait_high();
    #62.5 sda_drv = 1'b0;
    #62.5 scl_drv = 1'b0;
    #62.5;
  endtask : start
  // Stop condition
  task automatic stop();
    sda_drv = 1'b0;
    #31.25 scl_drv = 1'b1;
    wait_high();
    #62.5 sda_drv = 1'b1;
    #125;
  endtask : stop
  // Byte out, MSB first, then the slave's acknowledge
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask : send
  // Byte in, then our acknowledge or refusal
  task automatic recv(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask : recv
endmodule : isw_i2c_master

/* File: dv/test_i2c_slave_word_handler.sv */
// Self-checking testbench for the I2C slave word handler.
`timescale 1ns/1ps
module test_i2c_slave_word_handler;
  import isw_pkg::*;
  // Short low hold keeps the run brief; figures below scale from it
  localparam int CLOCK_LOW_PERIOD_SIM = 8;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, arb_lost = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd_word;
  logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe_n, sda_o, sda_oe_n, irq;
  logic scl_drv, sda_drv, stall_err, ack;
  logic [1:0] bresp, rresp, last_resp;
  logic [6:0] own;
  logic [7:0] b, got;
  int bad_count = 0, num_checks = 0, irq_count = 0, n_irq = 0;
  // Open-drain wires with pull-ups
  wire logic scl_w = scl_drv & (scl_oe_n | scl_o);
  wire logic sda_w = sda_drv & (sda_oe_n | sda_o);

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (irq === 1'b1) irq_count <= irq_count + 1;

  isw_slave #(.CLOCK_LOW_PERIOD_CYC(CLOCK_LOW_PERIOD_SIM)) dut_u (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .arb_lost_in(arb_lost), .transfer_interrupt(irq));
  isw_i2c_master m_u (.scl_w(scl_w), .sda_w(sda_w), .scl_drv(scl_drv), .sda_drv(sda_drv),
    .stall_err(stall_err));
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    num_checks++;
    if (got_v !== exp_v) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask : chk
  task automatic give_up();
    chk(32'h0, 32'h1);
    report_and_stop();
  endtask : give_up
  // Expected status word; pending is always expected clear here
  function automatic logic [31:0] st(input logic lrb, gc, aas, al, trx);
    return (32'(lrb) << ISW_ST_LRB) | (32'(gc) << ISW_ST_GC) | (32'(aas) << ISW_ST_AAS) |
      (32'(al) << ISW_ST_AL) | (32'(trx) << ISW_ST_TRX);
  endfunction : st
  // Handshakes are sampled at the falling edge, where they equal the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    b_hs = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64 && !b_hs; n++) begin
      @(negedge clk_sys);
      aw_hs = awvalid & awready;
      w_hs = wvalid & wready;
      b_hs = bvalid & bready;
      last_resp = bresp;
      @(posedge clk_sys);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
    end
    if (!b_hs) give_up();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    logic ar_hs, r_hs;
    r_hs = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64 && !r_hs; n++) begin
      @(negedge clk_sys);
      ar_hs = arvalid & arready;
      r_hs = rvalid & rready;
      rd_word = rdata;
      last_resp = rresp;
      @(posedge clk_sys);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) rready <= 1'b0;
    end
    if (!r_hs) give_up();
  endtask : axi_rd
  // Exactly one more interrupt pulse is expected
  task automatic wait_irq();
    for (int n = 0; n < 4000 && irq_count <= n_irq; n++) @(negedge clk_sys);
    if (irq_count <= n_irq) give_up();
    n_irq++;
    chk(32'(irq_count), 32'(n_irq));
    chk(32'(scl_oe_n), 32'h0);
  endtask : wait_irq
  task automatic stat(input logic [31:0] mask, input logic [31:0] exp_v);
    axi_rd(ISW_OFF_STAT);
    chk(rd_word & mask, exp_v);
  endtask : stat
  // Release by dummy read (0), data write (1) or pending set (2), then time the low hold
  task automatic rel(input int kind, input logic [7:0] d);
    int n;
    if (kind == 0) axi_rd(ISW_OFF_DATA);
    else if (kind == 1) axi_wr(ISW_OFF_DATA, {24'h0, d});
    else axi_wr(ISW_OFF_CTRL, 32'h1);
    for (n = 0; n < 64 && scl_oe_n !== 1'b1; n++) @(negedge clk_sys);
    chk(32'(n >= CLOCK_LOW_PERIOD_SIM - 2 && n <= CLOCK_LOW_PERIOD_SIM + 4), 32'h1);
  endtask : rel
  // Start, address byte (optionally losing arbitration meanwhile), interrupt and flags
  task automatic hit(input logic [7:0] ab, input bit lose, input logic [31:0] mask, input logic [31:0] exp_v);
    m_u.start();
    fork
      m_u.send(ab, ack);
      if (lose) begin
        repeat (40) @(posedge clk_sys);
        arb_lost <= 1'b1;
        @(posedge clk_sys);
        arb_lost <= 1'b0;
      end
    join
    chk(32'(ack), 32'h0);
    wait_irq();
    stat(mask, exp_v);
  endtask : hit
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(64262));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    own = 7'h08 + 7'($urandom % 112);
    // Reset flags and an unmapped offset
    stat(32'h1e, 32'h0);
    axi_rd(8'h10);
    chk({rd_word[29:0], last_resp}, {30'h0, ISW_RESP_SLVERR});
    axi_wr(8'h10, 32'h5a);
    chk(32'(last_resp), 32'(ISW_RESP_SLVERR));
    axi_wr(ISW_OFF_ADDR, 32'(own));
    axi_wr(ISW_OFF_CTRL, 32'h0);
    // Own address, write direction, then boundary and random data words
    hit({own, 1'b0}, 1'b0, 32'h3f, st(0, 0, 1, 0, 0));
    rel(0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      m_u.send(b, ack);
      chk(32'(ack), 32'h0);
      wait_irq();
      stat(32'h3f, st(0, 0, 0, 0, 0));
      rel(0, 8'h00);
      chk(rd_word & 32'hff, 32'(b));
    end
    // Short word of three bits; the pending write below restores full words
    axi_wr(ISW_OFF_CTRL, 32'h30);
    for (int k = 2; k >= 0; k--) m_u.bit_io(b[k], got[k]);
    m_u.bit_io(1'b1, ack);
    chk(32'(ack), 32'h0);
    wait_irq();
    rel(0, 8'h00);
    chk(rd_word & 32'h7, 32'(b[2:0]));
    m_u.stop();
    // General call, released through the pending bit, cleared by stop
    hit(8'h00, 1'b0, 32'h3f, st(0, 1, 1, 0, 0));
    rel(2, 8'h00);
    m_u.stop();
    stat(32'h02, 32'h0);
    // Read direction: one acknowledged word, one refused
    hit({own, 1'b1}, 1'b0, 32'h3f, st(0, 0, 1, 0, 1));
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      rel(1, b);
      m_u.recv(i == 1, got);
      chk(32'(got), 32'(b));
      wait_irq();
      stat(32'h3f, st(i == 1, 0, 0, 0, 1));
    end
    rel(2, 8'h00);
    chk(32'(sda_oe_n), 32'h1);
    m_u.stop();
    // Arbitration lost during the address, read then write direction
    for (int i = 1; i >= 0; i--) begin
      axi_wr(ISW_OFF_CTRL, 32'h4);
      hit({own, i[0]}, 1'b1, 32'h3b, st(0, 0, 0, 1, i[0]));
      if (i == 1) begin
        b = 8'($urandom);
        rel(1, b);
        m_u.recv(1'b1, got);
        chk(32'(got), 32'(b));
        wait_irq();
        rel(2, 8'h00);
      end else begin
        rel(0, 8'h00);
      end
      m_u.stop();
    end
    chk(32'(irq_count), 32'(n_irq));
    chk(32'(stall_err), 32'h0);
    report_and_stop();
  end
endmodule : test_i2c_slave_word_handler
